// file: core/rip_top.sv
// reset configuration, option register and reset/interrupt priority resolution
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "rip_cfg.svh"
// Function
// [R1] protected option bits: once, first 64 cycles
// [R2] sense bit 0 level, 1 falling edge
// [R3] clock monitor enable; fail starts reset
// [R4] watchdog clock divided by 2^15, scaled
// [R5] reset clears converter power-up only
// [R6] reset disables nonvolatile programming controls
// [R7] promotion field resets to 0110
// [R8] pin comes up level-sensitive after reset
// [R9] mode pins latched at reset release
// [R10] special mode: write switches operating mode
// [R11] reset sets oscillator startup delay
// [R12] fixed priority, one maskable promotable
// [R13] six non-maskable sources in fixed order
// [R14] fifteen maskable sources in fixed order
// [R15] acknowledge sets global mask; maskables wait
// [R16] nmi mask set by hardware, cleared by software
// [R17] present highest pending source each cycle
// [R18] promoted maskable ranks above the rest
module rip_top #(
	parameter int WDOG_PRESCALE = `RIP_WDOG_PRESCALE
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire rip_pkg::rip_addr_t addr,
	input wire rip_pkg::rip_byte_t wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output rip_pkg::rip_byte_t rd_data,
	input wire logic mode_select_a_pin,
	input wire logic mode_select_b_pin,
	input wire logic ext_int_pin_n,
	input wire logic nonmaskable_int_pin_n,
	input wire logic clk_fail_det,
	input wire logic illegal_op_req,
	input wire logic software_trap_instr_req,
	input wire rip_pkg::rip_msrc_t periph_int_req,
	input wire logic vec_ack,
	output logic vec_valid,
	output rip_pkg::rip_vec_t vec_id,
	output logic glob_int_mask,
	output logic nmi_mask,
	output logic sys_reset_req,
	output logic boot_rom_en,
	output logic special_mode_flag,
	output logic mode_a_flag,
	output logic converter_power_up,
	output logic osc_startup_delay_en,
	output rip_pkg::rip_byte_t nvm_prog_ctrl,
	output logic irq
);
	import rip_pkg::*;

	// ********************************
	// declarations
	// ********************************
	logic ext_int_edge_sense_r;
	logic clock_monitor_en_r;
	logic [1:0] watchdog_rate_sel_r;
	logic conv_clk_sel_r;
	rip_idx_t psel_r;
	logic opt_written_r;
	logic [6:0] win_cnt_r;
	logic strap_done_r;
	logic [2:0] status_r;
	logic [2:0] mask_r;
	logic por_pend_r;
	logic clkmon_pend_r;
	logic wdog_pend_r;
	logic edge_pend_r;
	logic ext_pin_prev_r;
	logic wr_opt;
	logic wr_prio;
	logic wr_ccr;
	logic prot_ok;
	logic ack_ext;
	logic ext_fall;
	logic ext_req;
	logic nmi_req;
	logic wdog_timeout;
	logic clkmon_fire;
	logic msk_valid;
	rip_idx_t msk_idx;
	rip_msrc_t msk_req;
	logic vec_valid_nxt;
	rip_vec_t vec_id_nxt;
	rip_byte_t opt_view;
	rip_byte_t prio_view;
	rip_byte_t rd_nxt;

	assign wr_opt = wr_en && addr == `RIP_OFF_OPTION;
	assign wr_prio = wr_en && addr == `RIP_OFF_PRIO;
	assign wr_ccr = wr_en && addr == `RIP_OFF_CCR;

	// ********************************
	// option register
	// ********************************
	// window closes for good at 64; special modes ignore it
	assign prot_ok = special_mode_flag || (!opt_written_r && win_cnt_r < `RIP_OPT_WIN_CYC); // [R1]

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			win_cnt_r <= 7'h00;
		end else if (win_cnt_r < `RIP_OPT_WIN_CYC) begin
			win_cnt_r <= win_cnt_r + 7'h01; // [R1]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			opt_written_r <= 1'b0;
		end else if (wr_opt && prot_ok && !special_mode_flag) begin
			opt_written_r <= 1'b1; // [R1]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ext_int_edge_sense_r <= 1'b0; // [R8]
			osc_startup_delay_en <= 1'b1; // [R11]
			watchdog_rate_sel_r <= 2'b00;
		end else if (wr_opt && prot_ok) begin
			ext_int_edge_sense_r <= wr_data[`RIP_OPT_EDGE]; // [R1]
			osc_startup_delay_en <= wr_data[`RIP_OPT_DLY];
			watchdog_rate_sel_r <= wr_data[`RIP_OPT_RATE_HI:`RIP_OPT_RATE_LO];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			clock_monitor_en_r <= 1'b0; // [R3]
			converter_power_up <= 1'b0; // [R5]
		end else if (wr_opt) begin
			clock_monitor_en_r <= wr_data[`RIP_OPT_CME]; // [R3]
			converter_power_up <= wr_data[`RIP_OPT_CONVERTER_POWER_UP];
		end
	end

	// left without reset on purpose: converter setup is undefined out of reset
	always_ff @(posedge core_clk) begin
		if (wr_opt) begin
			conv_clk_sel_r <= wr_data[`RIP_OPT_CSEL]; // [R5]
		end
	end

	always_comb begin
		opt_view = 8'h00;
		opt_view[`RIP_OPT_CONVERTER_POWER_UP] = converter_power_up;
		opt_view[`RIP_OPT_CSEL] = conv_clk_sel_r;
		opt_view[`RIP_OPT_EDGE] = ext_int_edge_sense_r;
		opt_view[`RIP_OPT_DLY] = osc_startup_delay_en;
		opt_view[`RIP_OPT_CME] = clock_monitor_en_r;
		opt_view[`RIP_OPT_RATE_HI:`RIP_OPT_RATE_LO] = watchdog_rate_sel_r;
	end

	// ********************************
	// mode latches and promotion field
	// ********************************
	// straps caught at the first edge after release, never by the reset itself
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			strap_done_r <= 1'b0;
		end else begin
			strap_done_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			boot_rom_en <= 1'b0;
			special_mode_flag <= 1'b0;
			mode_a_flag <= 1'b0;
		end else if (!strap_done_r) begin
			boot_rom_en <= !mode_select_b_pin; // [R9]
			special_mode_flag <= !mode_select_b_pin; // [R9]
			mode_a_flag <= mode_select_a_pin; // [R9]
		end else if (wr_prio && special_mode_flag) begin
			boot_rom_en <= wr_data[`RIP_PRIO_BOOT]; // [R10]
			special_mode_flag <= wr_data[`RIP_PRIO_SPECIAL_MODE_FLAG]; // [R10]
			mode_a_flag <= wr_data[`RIP_PRIO_MDA]; // [R10]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			psel_r <= `RIP_PSEL_RST; // [R7]
		end else if (wr_prio) begin
			psel_r <= wr_data[`RIP_PRIO_PSEL_HI:`RIP_PRIO_PSEL_LO]; // [R12]
		end
	end

	always_comb begin
		prio_view = 8'h00;
		prio_view[`RIP_PRIO_BOOT] = boot_rom_en;
		prio_view[`RIP_PRIO_SPECIAL_MODE_FLAG] = special_mode_flag;
		prio_view[`RIP_PRIO_MDA] = mode_a_flag;
		prio_view[`RIP_PRIO_PSEL_HI:`RIP_PRIO_PSEL_LO] = psel_r;
	end

	// ********************************
	// nonvolatile programming controls
	// ********************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			nvm_prog_ctrl <= 8'h00; // [R6]
		end else if (wr_en && addr == `RIP_OFF_NVM) begin
			nvm_prog_ctrl <= wr_data;
		end
	end

	// ********************************
	// watchdog and clock monitor
	// ********************************
	rip_wdog_div #(
		.PRESCALE(WDOG_PRESCALE)
	) u_wdog (
		.core_clk(core_clk),
		.rstn(rstn),
		.restart(wr_en && addr == `RIP_OFF_WDOG),
		.rate_sel(watchdog_rate_sel_r),
		.timeout(wdog_timeout)
	);

	assign clkmon_fire = clock_monitor_en_r && clk_fail_det; // [R3]

	// ********************************
	// pending sources
	// ********************************
	assign ext_fall = ext_pin_prev_r && !ext_int_pin_n;
	assign ack_ext = vec_ack && vec_valid && vec_id == `RIP_VEC_MASK0;
	assign ext_req = ext_int_edge_sense_r ? edge_pend_r : !ext_int_pin_n; // [R2]
	assign nmi_req = !nonmaskable_int_pin_n && !nmi_mask;
	assign msk_req = {periph_int_req[14:1], ext_req};

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ext_pin_prev_r <= 1'b1;
		end else begin
			ext_pin_prev_r <= ext_int_pin_n;
		end
	end

	// a new edge in the acknowledge cycle is kept
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			edge_pend_r <= 1'b0;
		end else if (ext_int_edge_sense_r && ext_fall) begin
			edge_pend_r <= 1'b1; // [R2]
		end else if (ack_ext || !ext_int_edge_sense_r) begin
			edge_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			por_pend_r <= 1'b1; // [R13]
		end else if (vec_ack && vec_valid && vec_id == `RIP_VEC_POR) begin
			por_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			clkmon_pend_r <= 1'b0;
		end else if (clkmon_fire) begin
			clkmon_pend_r <= 1'b1; // [R3]
		end else if (vec_ack && vec_valid && vec_id == `RIP_VEC_CLKMON) begin
			clkmon_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wdog_pend_r <= 1'b0;
		end else if (wdog_timeout) begin
			wdog_pend_r <= 1'b1;
		end else if (vec_ack && vec_valid && vec_id == `RIP_VEC_WDOG) begin
			wdog_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= clkmon_pend_r || wdog_pend_r || clkmon_fire || wdog_timeout;
		end
	end

	// ********************************
	// core masks
	// ********************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			glob_int_mask <= 1'b1;
		end else if (vec_ack && vec_valid) begin
			glob_int_mask <= 1'b1; // [R15]
		end else if (wr_ccr) begin
			glob_int_mask <= wr_data[`RIP_CCR_I];
		end
	end

	// software may only clear it; hardware set wins
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			nmi_mask <= 1'b1; // [R16]
		end else if (vec_ack && vec_valid && vec_id == `RIP_VEC_NMI) begin
			nmi_mask <= 1'b1; // [R16]
		end else if (wr_ccr && !wr_data[`RIP_CCR_X]) begin
			nmi_mask <= 1'b0; // [R16]
		end
	end

	// ********************************
	// priority resolution
	// ********************************
	rip_prio_enc u_enc (
		.req(msk_req),
		.psel(psel_r),
		.valid(msk_valid),
		.idx(msk_idx)
	);

	always_comb begin
		vec_valid_nxt = 1'b1;
		vec_id_nxt = `RIP_VEC_POR;
		if (por_pend_r) begin
			vec_id_nxt = `RIP_VEC_POR; // [R13]
		end else if (clkmon_pend_r) begin
			vec_id_nxt = `RIP_VEC_CLKMON; // [R13]
		end else if (wdog_pend_r) begin
			vec_id_nxt = `RIP_VEC_WDOG; // [R13]
		end else if (nmi_req) begin
			vec_id_nxt = `RIP_VEC_NMI; // [R13]
		end else if (illegal_op_req) begin
			vec_id_nxt = `RIP_VEC_ILLOP; // [R13]
		end else if (software_trap_instr_req) begin
			vec_id_nxt = `RIP_VEC_SWI; // [R13]
		end else if (msk_valid && !glob_int_mask) begin
			vec_id_nxt = `RIP_VEC_MASK0 + {1'b0, msk_idx}; // [R15] [R12]
		end else begin
			vec_valid_nxt = 1'b0;
		end
	end

	// one cycle of latency keeps the outputs flopped; ack drops the request at once
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			vec_valid <= 1'b0;
			vec_id <= `RIP_VEC_POR;
		end else begin
			vec_valid <= vec_valid_nxt && !(vec_ack && vec_valid); // [R17]
			vec_id <= vec_id_nxt; // [R17]
		end
	end

	// ********************************
	// event status and interrupt
	// ********************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			status_r <= 3'b000;
		end else begin
			for (int b = 0; b < 3; b++) begin
				if ((b == `RIP_ST_WDOG && wdog_timeout) || (b == `RIP_ST_CLKF && clkmon_fire) ||
					(b == `RIP_ST_EDGE && ext_fall && ext_int_edge_sense_r)) begin
					status_r[b] <= 1'b1;
				end else if (wr_en && addr == `RIP_OFF_STATUS && wr_data[b]) begin
					status_r[b] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			mask_r <= 3'b000;
		end else if (wr_en && addr == `RIP_OFF_MASK) begin
			mask_r <= wr_data[2:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_r & mask_r);
		end
	end

	// ********************************
	// read port
	// ********************************
	always_comb begin
		unique case (addr)
			`RIP_OFF_OPTION: rd_nxt = opt_view;
			`RIP_OFF_PRIO: rd_nxt = prio_view;
			`RIP_OFF_STATUS: rd_nxt = {5'b00000, status_r};
			`RIP_OFF_MASK: rd_nxt = {5'b00000, mask_r};
			`RIP_OFF_CCR: rd_nxt = {6'b000000, nmi_mask, glob_int_mask};
			`RIP_OFF_VECTOR: rd_nxt = {vec_valid, 2'b00, vec_id};
			`RIP_OFF_WDOG: rd_nxt = {7'b0000000, wdog_pend_r};
			`RIP_OFF_NVM: rd_nxt = nvm_prog_ctrl;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= rd_nxt;
		end else begin
			rd_data <= 8'h00;
		end
	end
endmodule : rip_top

// file: core/rip_cfg.svh
// offsets, field positions, reset values and counts for the reset/interrupt priority block
`ifndef RIP_CFG_SVH
`define RIP_CFG_SVH

// ********************************
// register offsets
// ********************************
`define RIP_OFF_OPTION 3'h0
`define RIP_OFF_PRIO 3'h1
`define RIP_OFF_STATUS 3'h2
`define RIP_OFF_MASK 3'h3
`define RIP_OFF_CCR 3'h4
`define RIP_OFF_VECTOR 3'h5
`define RIP_OFF_WDOG 3'h6
`define RIP_OFF_NVM 3'h7

// ********************************
// option register fields
// ********************************
`define RIP_OPT_CONVERTER_POWER_UP 7
`define RIP_OPT_CSEL 6
`define RIP_OPT_EDGE 5
`define RIP_OPT_DLY 4
`define RIP_OPT_CME 3
`define RIP_OPT_RATE_HI 1
`define RIP_OPT_RATE_LO 0

// ********************************
// priority and mode register fields
// ********************************
`define RIP_PRIO_BOOT 7
`define RIP_PRIO_SPECIAL_MODE_FLAG 6
`define RIP_PRIO_MDA 5
`define RIP_PRIO_PSEL_HI 3
`define RIP_PRIO_PSEL_LO 0
`define RIP_PSEL_RST 4'h6
`define RIP_PSEL_BIAS 4'hA

// ********************************
// status, mask and core mask fields
// ********************************
`define RIP_ST_WDOG 0
`define RIP_ST_CLKF 1
`define RIP_ST_EDGE 2
`define RIP_CCR_I 0
`define RIP_CCR_X 1

// ********************************
// vector identities
// ********************************
`define RIP_VEC_POR 5'h00
`define RIP_VEC_CLKMON 5'h01
`define RIP_VEC_WDOG 5'h02
`define RIP_VEC_NMI 5'h03
`define RIP_VEC_ILLOP 5'h04
`define RIP_VEC_SWI 5'h05
`define RIP_VEC_MASK0 5'h06

// ********************************
// counts
// ********************************
`define RIP_OPT_WIN_CYC 7'h40
`define RIP_WDOG_PRESCALE 32768
`define RIP_WDOG_SCALE0 8'h01
`define RIP_WDOG_SCALE1 8'h04
`define RIP_WDOG_SCALE2 8'h10
`define RIP_WDOG_SCALE3 8'h40

`endif

// file: core/rip_pkg.sv
// types shared by the reset/interrupt priority block
package rip_pkg;
	typedef logic [7:0] rip_byte_t;
	typedef logic [2:0] rip_addr_t;
	typedef logic [4:0] rip_vec_t;
	typedef logic [14:0] rip_msrc_t;
	typedef logic [3:0] rip_idx_t;
endpackage : rip_pkg

// file: core/rip_prio_enc.sv
// maskable source picker with one promoted source
`timescale 1ns/1ps
`include "rip_cfg.svh"
module rip_prio_enc (
	input wire rip_pkg::rip_msrc_t req,
	input wire rip_pkg::rip_idx_t psel,
	output logic valid,
	output rip_pkg::rip_idx_t idx
);
	import rip_pkg::*;
	rip_idx_t prom;
	always_comb begin
		prom = psel + `RIP_PSEL_BIAS;
		valid = |req;
		idx = 4'h0;
		for (int i = 14; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i); // [R14]
			end
		end
		// index 15 names no source, so no promotion
		if (prom != 4'hF && req[prom]) begin
			idx = prom; // [R18]
		end
	end
endmodule : rip_prio_enc

// file: core/rip_wdog_div.sv
// watchdog prescaler and rate-scaled timeout
`timescale 1ns/1ps
`include "rip_cfg.svh"
module rip_wdog_div #(
	parameter int PRESCALE = `RIP_WDOG_PRESCALE
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic restart,
	input wire logic [1:0] rate_sel,
	output logic timeout
);
	import rip_pkg::*;
	logic [15:0] pre_r;
	logic [7:0] scl_r;
	logic [7:0] limit;
	logic tick;
	assign tick = (pre_r == 16'(PRESCALE - 1));
	always_comb begin
		unique case (rate_sel)
			2'b00: limit = `RIP_WDOG_SCALE0;
			2'b01: limit = `RIP_WDOG_SCALE1;
			2'b10: limit = `RIP_WDOG_SCALE2;
			2'b11: limit = `RIP_WDOG_SCALE3;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rstn || restart || tick) begin
			pre_r <= 16'h0000;
		end else begin
			pre_r <= pre_r + 16'h0001; // [R4]
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rstn || restart) begin
			scl_r <= 8'h00;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (tick) begin
				if (scl_r + 8'h01 == limit) begin
					scl_r <= 8'h00;
					timeout <= 1'b1; // [R4]
				end else begin
					scl_r <= scl_r + 8'h01;
				end
			end
		end
	end
endmodule : rip_wdog_div

// file: verif/rip_checker.sv
// concurrent checks on the reset/interrupt priority block ports
`timescale 1ns/1ps
module rip_checker (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic mode_select_a_pin,
	input wire logic mode_select_b_pin,
	input wire logic vec_ack,
	input wire logic vec_valid,
	input wire rip_pkg::rip_vec_t vec_id,
	input wire logic glob_int_mask,
	input wire logic nmi_mask,
	input wire logic boot_rom_en,
	input wire logic special_mode_flag,
	input wire logic mode_a_flag,
	input wire logic converter_power_up,
	input wire logic osc_startup_delay_en,
	input wire rip_pkg::rip_byte_t nvm_prog_ctrl
);
	import rip_pkg::*;
	// ****
	// properties
	// ****
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_rst_cfg;
		$rose(rstn) |-> osc_startup_delay_en && !converter_power_up && nvm_prog_ctrl == 8'h00;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("bad reset config");
	property p_rst_mask;
		$rose(rstn) |-> glob_int_mask && nmi_mask;
	endproperty
	a_rst_mask: assert property (p_rst_mask) else $error("masks open after reset");
	property p_straps;
		$rose(rstn) |=> mode_a_flag == $past(mode_select_a_pin)
			&& special_mode_flag == !$past(mode_select_b_pin)
			&& boot_rom_en == !$past(mode_select_b_pin);
	endproperty
	a_straps: assert property (p_straps) else $error("mode straps not latched");
	property p_por;
		$rose(rstn) |-> ##2 vec_valid && vec_id == 5'h00;
	endproperty
	a_por: assert property (p_por) else $error("power-on vector missing");
	property p_ack;
		vec_ack && vec_valid |=> !vec_valid && glob_int_mask;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not mask");
	property p_nmi_ack;
		vec_ack && vec_valid && vec_id == 5'h03 |=> nmi_mask;
	endproperty
	a_nmi_ack: assert property (p_nmi_ack) else $error("nmi ack left mask open");
	// only an nmi ack may raise the mask outside reset
	property p_nmi_src;
		$rose(nmi_mask) && $past(rstn) |-> $past(vec_ack && vec_valid && vec_id == 5'h03);
	endproperty
	a_nmi_src: assert property (p_nmi_src) else $error("nmi mask set by other");
	property p_held;
		glob_int_mask && $past(glob_int_mask) |-> !(vec_valid && vec_id >= 5'h06);
	endproperty
	a_held: assert property (p_held) else $error("maskable shown while masked");
endmodule : rip_checker

bind rip_top rip_checker u_chk (.core_clk, .rstn, .mode_select_a_pin, .mode_select_b_pin,
	.vec_ack, .vec_valid, .vec_id, .glob_int_mask, .nmi_mask, .boot_rom_en, .special_mode_flag,
	.mode_a_flag, .converter_power_up, .osc_startup_delay_en, .nvm_prog_ctrl);

// file: verif/rip_core_model.sv
// behavioural cpu core taking vector requests
`timescale 1ns/1ps
module rip_core_model (
	input wire logic core_clk,
	input wire logic ack_en,
	input wire logic [3:0] ack_delay,
	input wire logic vec_valid,
	input wire rip_pkg::rip_vec_t vec_id,
	output logic vec_ack,
	output rip_pkg::rip_vec_t last_id,
	output int ack_cnt
);
	import rip_pkg::*;
	logic [3:0] wait_r = 4'h0;
	initial begin
		vec_ack = 1'b0;
		last_id = 5'h00;
		ack_cnt = 0;
	end
	// never ack in the cycle after an ack: the block needs its gap cycle
	always @(posedge core_clk) begin
		vec_ack <= 1'b0;
		if (!ack_en || !vec_valid || vec_ack) begin
			wait_r <= 4'h0;
		end else if (wait_r < ack_delay) begin
			wait_r <= wait_r + 4'h1;
		end else begin
			vec_ack <= 1'b1;
			last_id <= vec_id;
			ack_cnt <= ack_cnt + 1;
			wait_r <= 4'h0;
		end
	end
endmodule : rip_core_model

// file: verif/tb_top.sv
// self-checking bench for the reset/interrupt priority block
`timescale 1ns/1ps
`include "rip_cfg.svh"
module tb_top;
	import rip_pkg::*;
	localparam int WDP = 2048;
	localparam int WD4 = `RIP_WDOG_SCALE1 * WDP;
	logic core_clk, vec_valid, glob_int_mask, nmi_mask, sys_reset_req, irq, vec_ack;
	logic boot_rom_en, special_mode_flag, mode_a_flag, converter_power_up, osc_startup_delay_en;
	logic rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ack_en = 1'b0, clk_fail_det = 1'b0;
	logic mode_select_a_pin = 1'b1, mode_select_b_pin = 1'b1, ext_int_pin_n = 1'b1;
	logic nonmaskable_int_pin_n = 1'b1, illegal_op_req = 1'b0, software_trap_instr_req = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	rip_addr_t addr = 3'h0;
	rip_byte_t wr_data = 8'h00;
	rip_byte_t rd_data, nvm_prog_ctrl;
	rip_msrc_t periph_int_req = 15'h0000;
	rip_vec_t vec_id, last_id, id;
	int ack_cnt, n, fail_count = 0, checked = 0;
	rip_top #(.WDOG_PRESCALE(WDP)) DUT (.core_clk, .rstn, .addr, .wr_data, .wr_en, .rd_en,
		.rd_data, .mode_select_a_pin, .mode_select_b_pin, .ext_int_pin_n, .nonmaskable_int_pin_n,
		.clk_fail_det, .illegal_op_req, .software_trap_instr_req, .periph_int_req, .vec_ack,
		.vec_valid, .vec_id, .glob_int_mask, .nmi_mask, .sys_reset_req, .boot_rom_en,
		.special_mode_flag, .mode_a_flag, .converter_power_up, .osc_startup_delay_en,
		.nvm_prog_ctrl, .irq);
	rip_core_model u_core (.core_clk, .ack_en, .ack_delay, .vec_valid, .vec_id, .vec_ack,
		.last_id, .ack_cnt);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ****
	// tasks
	// ****
	task automatic chk(input rip_byte_t got, input rip_byte_t exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input rip_addr_t a, input rip_byte_t d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input rip_addr_t a, input rip_byte_t m, input rip_byte_t e);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data & m, e);
	endtask : rd
	// let the core ack one vector, then drop its level source at the ack edge
	task automatic take(input rip_vec_t v);
		int c;
		c = ack_cnt;
		@(posedge core_clk);
		ack_en <= 1'b1;
		for (int i = 0; i < 60 && ack_cnt == c; i++) @(negedge core_clk);
		if (ack_cnt == c) begin
			fail_count++;
			test_done();
		end
		@(posedge core_clk);
		ack_en <= 1'b0;
		case (v)
			5'h01: clk_fail_det <= 1'b0;
			5'h03: nonmaskable_int_pin_n <= 1'b1;
			5'h04: illegal_op_req <= 1'b0;
			5'h05: software_trap_instr_req <= 1'b0;
			5'h06: ext_int_pin_n <= 1'b1;
			default: if (v > 5'h06) periph_int_req[v - 5'h06] <= 1'b0;
		endcase
		chk({3'h0, last_id}, {3'h0, v});
	endtask : take
	task automatic do_reset(input logic a, input logic b);
		@(posedge core_clk);
		rstn <= 1'b0;
		mode_select_a_pin <= a;
		mode_select_b_pin <= b;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		take(5'h00);
	endtask : do_reset
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// ****
	// scenarios
	// ****
	initial begin
		do_reset(1'b1, 1'b1);
		rd(`RIP_OFF_OPTION, 8'hBC, 8'h10);
		rd(`RIP_OFF_PRIO, 8'hFF, 8'h26);
		rd(`RIP_OFF_NVM, 8'hFF, 8'h00);
		// promote the serial source, then raise every source but clock fail and watchdog at once
		wr(`RIP_OFF_NVM, 8'h5A);
		rd(`RIP_OFF_NVM, 8'hFF, 8'h5A);
		wr(`RIP_OFF_PRIO, 8'h04);
		wr(`RIP_OFF_CCR, 8'h00);
		@(posedge core_clk);
		nonmaskable_int_pin_n <= 1'b0;
		illegal_op_req <= 1'b1;
		software_trap_instr_req <= 1'b1;
		periph_int_req <= 15'h7FFE;
		ext_int_pin_n <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			id = (i < 3) ? 5'(i + 3) : (i == 3) ? 5'h14 : 5'(i + 2);
			if (i == 3) begin
				repeat (6) @(posedge core_clk);
				#1;
				chk({7'h00, vec_valid}, 8'h00);
			end
			if (i > 2) wr(`RIP_OFF_CCR, 8'h00);
			take(id);
		end
		rd(`RIP_OFF_STATUS, 8'h04, 8'h00);
		// software may not set the nmi mask
		wr(`RIP_OFF_CCR, 8'h02);
		rd(`RIP_OFF_CCR, 8'h02, 8'h00);
		// window, edge sense, clock monitor and watchdog, slow core
		do_reset(1'b1, 1'b1);
		ack_delay <= 4'h6;
		rd(`RIP_OFF_NVM, 8'hFF, 8'h00);
		wr(`RIP_OFF_OPTION, 8'h28);
		rd(`RIP_OFF_OPTION, 8'hBC, 8'h28);
		@(posedge core_clk);
		clk_fail_det <= 1'b1;
		repeat (3) @(posedge core_clk);
		clk_fail_det <= 1'b0;
		#1;
		chk({7'h00, sys_reset_req}, 8'h01);
		wr(`RIP_OFF_MASK, 8'h02);
		repeat (2) @(posedge core_clk);
		#1;
		chk({7'h00, irq}, 8'h01);
		wr(`RIP_OFF_STATUS, 8'h02);
		repeat (2) @(posedge core_clk);
		#1;
		chk({7'h00, irq}, 8'h00);
		take(5'h01);
		ext_int_pin_n <= 1'b0;
		rd(`RIP_OFF_STATUS, 8'h04, 8'h04);
		wr(`RIP_OFF_CCR, 8'h00);
		take(5'h06);
		wr(`RIP_OFF_WDOG, 8'h00);
		for (n = 0; n < 3000 && !sys_reset_req; n++) @(negedge core_clk);
		chk({7'h00, n > WDP - 8 && n < WDP + 12}, 8'h01);
		if (n == 3000) test_done();
		rd(`RIP_OFF_WDOG, 8'h01, 8'h01);
		rd(`RIP_OFF_VECTOR, 8'hFF, 8'h82);
		take(5'h02);
		wr(`RIP_OFF_OPTION, 8'h10);
		rd(`RIP_OFF_OPTION, 8'hBC, 8'h20);
		@(posedge core_clk);
		clk_fail_det <= 1'b1;
		repeat (8) @(posedge core_clk);
		clk_fail_det <= 1'b0;
		#1;
		chk({7'h00, sys_reset_req}, 8'h00);
		// write after the window closes, normal mode
		do_reset(1'b1, 1'b1);
		repeat (70) @(posedge core_clk);
		wr(`RIP_OFF_OPTION, 8'h20);
		rd(`RIP_OFF_OPTION, 8'hBC, 8'h10);
		// special mode: writes any time, rate scaling, mode switch
		do_reset(1'b0, 1'b0);
		rd(`RIP_OFF_PRIO, 8'hEF, 8'hC6);
		repeat (70) @(posedge core_clk);
		wr(`RIP_OFF_OPTION, 8'h28);
		rd(`RIP_OFF_OPTION, 8'hBC, 8'h28);
		wr(`RIP_OFF_OPTION, 8'h11);
		rd(`RIP_OFF_OPTION, 8'hBC, 8'h10);
		wr(`RIP_OFF_WDOG, 8'h00);
		for (n = 0; n < 9000 && !sys_reset_req; n++) @(negedge core_clk);
		chk({7'h00, n > WD4 - 8 && n < WD4 + 12}, 8'h01);
		if (n == 9000) test_done();
		wr(`RIP_OFF_PRIO, 8'h26);
		#1;
		chk({6'h00, special_mode_flag, mode_a_flag}, 8'h01);
		test_done();
	end
endmodule : tb_top
